//--- design/awot_pkg.sv
package awot_pkg;

  // ************************************
  // Instruction word layout
  // ************************************
  localparam int OPCODE_HI = 31;
  localparam int OPCODE_LO = 26;
  localparam int SRC_A_HI = 25;
  localparam int SRC_A_LO = 21;
  localparam int SRC_B_HI = 20;
  localparam int SRC_B_LO = 16;
  localparam int DEST_HI = 15;
  localparam int DEST_LO = 11;
  localparam int ZERO_HI = 10;
  localparam int ZERO_LO = 6;
  localparam int FUNCT_HI = 5;
  localparam int FUNCT_LO = 0;

  localparam logic [5:0] OPC_REG_FORMAT = 6'h00;
  localparam logic [5:0] FN_TRAPPING_SUM = 6'h20;
  localparam logic [5:0] FN_WRAPPING_SUM = 6'h21;
  localparam logic [4:0] ZERO_FIELD_VALUE = 5'h00;

  // ************************************
  // Register file and reset values
  // ************************************
  localparam int NUM_REGS = 32;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [4:0] REG_ZERO_INDEX = 5'h00;

  typedef struct packed {
    logic [4:0] dest_index;
    logic [31:0] value;
  } awot_wb_t;

endpackage

//--- design/awot_core.sv
module awot_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Instruction issue
  input wire logic issue_valid,
  input wire logic [31:0] instr_word,
  // Operand preload
  input wire logic load_valid,
  input wire logic [4:0] load_index,
  input wire logic [31:0] load_value,
  // Results
  output logic retire_valid_q,
  output logic overflow_exc_q,
  output logic field_fault_q,
  output logic unsupported_q,
  output awot_pkg::awot_wb_t writeback_q,
  output logic wb_enable_q
);

  // ************************************
  // Decode
  // ************************************
  function automatic logic [32:0] sext33(input logic [31:0] v);
    sext33 = {v[31], v};
  endfunction

  wire logic [5:0] opcode = instr_word[awot_pkg::OPCODE_HI:awot_pkg::OPCODE_LO];
  wire logic [4:0] source_a_index = instr_word[awot_pkg::SRC_A_HI:awot_pkg::SRC_A_LO];
  wire logic [4:0] source_b_index = instr_word[awot_pkg::SRC_B_HI:awot_pkg::SRC_B_LO];
  wire logic [4:0] dest_index = instr_word[awot_pkg::DEST_HI:awot_pkg::DEST_LO];
  wire logic [4:0] zero_field = instr_word[awot_pkg::ZERO_HI:awot_pkg::ZERO_LO];
  wire logic [5:0] funct = instr_word[awot_pkg::FUNCT_HI:awot_pkg::FUNCT_LO];

  wire logic is_reg_fmt = (opcode == awot_pkg::OPC_REG_FORMAT);
  wire logic is_trapping = is_reg_fmt && (funct == awot_pkg::FN_TRAPPING_SUM);
  wire logic is_wrapping = is_reg_fmt && (funct == awot_pkg::FN_WRAPPING_SUM);
  wire logic is_sum = is_trapping || is_wrapping;
  wire logic zero_bad = (zero_field != awot_pkg::ZERO_FIELD_VALUE);

  // ************************************
  // General register file
  // ************************************
  logic [31:0] general_register_file [awot_pkg::NUM_REGS];

  wire logic [31:0] op_a = general_register_file[source_a_index];
  wire logic [31:0] op_b = general_register_file[source_b_index];

  // ************************************
  // Adder and overflow
  // ************************************
  wire logic [32:0] sum33 = sext33(op_a) + sext33(op_b);
  wire logic overflow = (sum33[32] != sum33[31]);

  wire logic exec_ok = issue_valid && is_sum && !zero_bad;
  wire logic trap_now = exec_ok && is_trapping && overflow;
  wire logic write_now = exec_ok && (is_wrapping || !overflow);
  // Register 0 stays fixed at zero
  wire logic load_now = load_valid && (load_index != awot_pkg::REG_ZERO_INDEX);
  wire logic sum_write_now = write_now && (dest_index != awot_pkg::REG_ZERO_INDEX);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < awot_pkg::NUM_REGS; i++) begin
        general_register_file[i] <= awot_pkg::REG_RESET;
      end
    end else begin
      if (load_now) begin
        general_register_file[load_index] <= load_value;
      end
      // Sum write wins over a preload to the same index
      if (sum_write_now) begin
        general_register_file[dest_index] <= sum33[31:0];
      end
    end
  end

  // ************************************
  // Result flops
  // ************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      retire_valid_q <= 1'b0;
      overflow_exc_q <= 1'b0;
      field_fault_q <= 1'b0;
      unsupported_q <= 1'b0;
      wb_enable_q <= 1'b0;
      writeback_q <= '0;
    end else begin
      retire_valid_q <= issue_valid;
      overflow_exc_q <= trap_now;
      field_fault_q <= issue_valid && is_sum && zero_bad;
      unsupported_q <= issue_valid && !is_sum;
      wb_enable_q <= write_now;
      writeback_q <= '{dest_index: dest_index, value: sum33[31:0]};
    end
  end

  // ************************************
  // Checks
  // ************************************
  sequence s_trap_issue;
    issue_valid && is_trapping && !zero_bad && overflow;
  endsequence

  sequence s_trap_clean;
    issue_valid && is_trapping && !zero_bad && !overflow;
  endsequence

  sequence s_wrap_issue;
    issue_valid && is_wrapping && !zero_bad;
  endsequence

  sequence s_field_issue;
    issue_valid && is_sum && zero_bad;
  endsequence

  sequence s_other_issue;
    issue_valid && !is_sum;
  endsequence

  sequence s_write_result;
    wb_enable_q && !overflow_exc_q && !field_fault_q && !unsupported_q;
  endsequence

  sequence s_trap_result;
    overflow_exc_q && !wb_enable_q && !field_fault_q && !unsupported_q;
  endsequence

  AST_TRAP_RAISES: assert property (@(posedge ref_clk) disable iff (reset)
    s_trap_issue |=> overflow_exc_q && !wb_enable_q)
    else $error("Overflowing trapping sum did not trap");

  AST_TRAP_NO_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    (s_trap_issue and (!(load_valid && load_index == dest_index)))
      |=> general_register_file[$past(dest_index)] == $past(general_register_file[dest_index]))
    else $error("Destination changed on overflow trap");

  AST_TRAP_OK_WRITES: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid && is_trapping && !zero_bad && !overflow
      |=> wb_enable_q && !overflow_exc_q && writeback_q.value == $past(op_a) + $past(op_b))
    else $error("Non-overflowing trapping sum not written");

  AST_WRAP_NEVER_TRAPS: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid && is_wrapping && !zero_bad |=> wb_enable_q && !overflow_exc_q)
    else $error("Wrapping sum trapped or did not write");

  AST_SUM_VALUE: assert property (@(posedge ref_clk) disable iff (reset)
    wb_enable_q |-> writeback_q.value == $past(op_a) + $past(op_b))
    else $error("Sum value wrong");

  AST_FIELD_FAULT: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid && is_sum && zero_bad |=> field_fault_q && !wb_enable_q && !overflow_exc_q)
    else $error("Nonzero zero field executed");

  AST_OVF_SIGNS: assert property (@(posedge ref_clk) disable iff (reset)
    overflow_exc_q |-> $past(op_a[31]) == $past(op_b[31]) && writeback_q.value[31] != $past(op_a[31]))
    else $error("Overflow flagged without sign overflow");

  AST_BOTH_DECODED: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid && is_reg_fmt && (funct == awot_pkg::FN_TRAPPING_SUM || funct == awot_pkg::FN_WRAPPING_SUM)
      |=> !unsupported_q)
    else $error("Sum encoding not decoded");

  AST_ORIGINAL_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    wb_enable_q && writeback_q.dest_index != awot_pkg::REG_ZERO_INDEX |->
      general_register_file[writeback_q.dest_index] == writeback_q.value)
    else $error("Written result not held in register file");

  AST_TRAP_FLAGS_ONLY: assert property (@(posedge ref_clk) disable iff (reset)
    s_trap_issue |=> s_trap_result)
    else $error("Overflow trap did not raise the exception alone");

  AST_CLEAN_WRITES: assert property (@(posedge ref_clk) disable iff (reset)
    s_trap_clean |=> s_write_result)
    else $error("Clean trapping sum did not write alone");

  AST_WRAP_WRITES: assert property (@(posedge ref_clk) disable iff (reset)
    s_wrap_issue |=> s_write_result ##0 (writeback_q.dest_index == $past(dest_index)))
    else $error("Wrapping sum did not write its destination");

  AST_WRAP_VALUE: assert property (@(posedge ref_clk) disable iff (reset)
    s_wrap_issue |=> writeback_q.value == $past(op_a) + $past(op_b))
    else $error("Wrapping sum value wrong");

  AST_FIELD_NO_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    (s_field_issue and (!(load_valid && load_index == dest_index)))
      |=> general_register_file[$past(dest_index)] == $past(general_register_file[dest_index]))
    else $error("Register changed by a word with a nonzero zero field");

  AST_OTHER_REFUSED: assert property (@(posedge ref_clk) disable iff (reset)
    s_other_issue |=> unsupported_q && !wb_enable_q && !overflow_exc_q && !field_fault_q)
    else $error("Unknown word not refused");

  AST_RETIRE_EACH: assert property (@(posedge ref_clk) disable iff (reset)
    issue_valid |=> retire_valid_q)
    else $error("Issued word did not retire");

  AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (reset)
    !issue_valid |=> !retire_valid_q && !wb_enable_q && !overflow_exc_q && !field_fault_q && !unsupported_q)
    else $error("Result flag raised without an issue");

  AST_ZERO_REG_FIXED: assert property (@(posedge ref_clk) disable iff (reset)
    general_register_file[awot_pkg::REG_ZERO_INDEX] == awot_pkg::REG_RESET)
    else $error("Register 0 is not zero");

  AST_LOAD_LANDS: assert property (@(posedge ref_clk) disable iff (reset)
    load_now && !(sum_write_now && dest_index == load_index)
      |=> general_register_file[$past(load_index)] == $past(load_value))
    else $error("Preload did not land");

  AST_DEST_FIELD: assert property (@(posedge ref_clk) disable iff (reset)
    wb_enable_q |-> writeback_q.dest_index == $past(dest_index))
    else $error("Written destination index wrong");

endmodule

//--- sim/awot_issuer.sv
module awot_issuer (
  // Request from bench
  input wire logic send,
  input wire logic [5:0] funct,
  input wire logic [4:0] zero_bits,
  input wire logic [4:0] src_a,
  input wire logic [4:0] src_b,
  input wire logic [4:0] dest,
  // Issue side
  output logic issue_valid,
  output logic [31:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] word;
  assign word = {awot_pkg::OPC_REG_FORMAT, src_a, src_b, dest, zero_bits, funct};
  assign issue_valid = send;
  // Idle word is inverted so a stale value is never mistaken for an issue
  assign instr_word = send ? word : ~word;
endmodule

//--- sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic send = 1'h0;
  logic [5:0] funct = 6'h00;
  logic [4:0] zero_bits = 5'h00;
  logic [4:0] dest = 5'h00;
  logic [4:0] src_a = 5'h01;
  logic [4:0] src_b = 5'h02;
  logic load_valid = 1'h0;
  logic [4:0] load_index = 5'h00;
  logic [31:0] load_value = 32'h0000_0000;
  logic issue_valid, retire_valid_q, overflow_exc_q, field_fault_q, unsupported_q, wb_enable_q;
  logic [31:0] instr_word;
  awot_pkg::awot_wb_t writeback_q;
  int n_mismatch = 0;
  int n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  awot_issuer i_src (.send(send), .funct(funct), .zero_bits(zero_bits), .src_a(src_a), .src_b(src_b), .dest(dest),
    .issue_valid(issue_valid), .instr_word(instr_word));
  awot_core i_dut (.ref_clk(ref_clk), .reset(reset), .issue_valid(issue_valid), .instr_word(instr_word),
    .load_valid(load_valid), .load_index(load_index), .load_value(load_value),
    .retire_valid_q(retire_valid_q), .overflow_exc_q(overflow_exc_q), .field_fault_q(field_fault_q),
    .unsupported_q(unsupported_q), .writeback_q(writeback_q), .wb_enable_q(wb_enable_q));
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic compare(input logic [40:0] got, input logic [40:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Result packs {wb_enable, overflow, field_fault, unsupported, writeback}
  task automatic load_reg(input logic [4:0] idx, input logic [31:0] v);
    @(posedge ref_clk);
    load_valid <= 1'h1;
    load_index <= idx;
    load_value <= v;
    @(posedge ref_clk);
    load_valid <= 1'h0;
  endtask
  task automatic issue(input logic [5:0] fn, input logic [4:0] zb, input logic [4:0] sa, input logic [4:0] sb,
    input logic [4:0] d, output logic [40:0] res);
    @(posedge ref_clk);
    send <= 1'h1;
    funct <= fn;
    zero_bits <= zb;
    src_a <= sa;
    src_b <= sb;
    dest <= d;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      send <= 1'h0;
      #1;
      if (retire_valid_q === 1'h1) break;
    end
    if (retire_valid_q !== 1'h1) begin
      n_mismatch++;
      tally_and_finish();
    end
    res = {wb_enable_q, overflow_exc_q, field_fault_q, unsupported_q, writeback_q};
  endtask
  task automatic wrap_sum_writes();
    logic [40:0] r;
    load_reg(5'h01, 32'h7fff_ffff);
    load_reg(5'h02, 32'h0000_0001);
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h01, 5'h02, 5'h05, r);
    compare(r, {4'h8, 5'h05, 32'h8000_0000});
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h05, 5'h00, 5'h06, r);
    compare(r, {4'h8, 5'h06, 32'h8000_0000});
  endtask
  task automatic trap_sum_writes();
    logic [40:0] r;
    load_reg(5'h01, 32'h1234_5678);
    load_reg(5'h02, 32'h0000_1111);
    issue(awot_pkg::FN_TRAPPING_SUM, 5'h00, 5'h01, 5'h02, 5'h1f, r);
    compare(r, {4'h8, 5'h1f, 32'h1234_6789});
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h1f, 5'h00, 5'h1e, r);
    compare(r, {4'h8, 5'h1e, 32'h1234_6789});
    load_reg(5'h01, 32'hffff_ffff);
    load_reg(5'h02, 32'h8000_0001);
    issue(awot_pkg::FN_TRAPPING_SUM, 5'h00, 5'h01, 5'h02, 5'h1d, r);
    compare(r, {4'h8, 5'h1d, 32'h8000_0000});
  endtask
  task automatic trap_overflow_refused();
    logic [40:0] r;
    load_reg(5'h03, 32'h1111_1111);
    load_reg(5'h01, 32'h8000_0000);
    load_reg(5'h02, 32'h8000_0000);
    issue(awot_pkg::FN_TRAPPING_SUM, 5'h00, 5'h01, 5'h02, 5'h03, r);
    compare(r, {4'h4, 5'h03, 32'h0000_0000});
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h03, 5'h00, 5'h04, r);
    compare(r, {4'h8, 5'h04, 32'h1111_1111});
    load_reg(5'h01, 32'h7fff_ffff);
    load_reg(5'h02, 32'h0000_0001);
    issue(awot_pkg::FN_TRAPPING_SUM, 5'h00, 5'h01, 5'h02, 5'h03, r);
    compare(r, {4'h4, 5'h03, 32'h8000_0000});
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h03, 5'h00, 5'h04, r);
    compare(r, {4'h8, 5'h04, 32'h1111_1111});
  endtask
  task automatic zero_field_refused();
    logic [40:0] r;
    issue(awot_pkg::FN_TRAPPING_SUM, 5'h10, 5'h01, 5'h02, 5'h07, r);
    compare({r[40:37], 37'h0}, {4'h2, 37'h0});
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h01, 5'h01, 5'h02, 5'h07, r);
    compare({r[40:37], 37'h0}, {4'h2, 37'h0});
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h07, 5'h00, 5'h08, r);
    compare(r, {4'h8, 5'h08, 32'h0000_0000});
  endtask
  task automatic other_funct_refused();
    logic [40:0] r;
    issue(6'h22, 5'h00, 5'h01, 5'h02, 5'h07, r);
    compare({r[40:37], 37'h0}, {4'h1, 37'h0});
  endtask
  task automatic reg_zero_dropped();
    logic [40:0] r;
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h01, 5'h02, 5'h00, r);
    compare(r, {4'h8, 5'h00, 32'h8000_0000});
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h00, 5'h00, 5'h09, r);
    compare(r, {4'h8, 5'h09, 32'h0000_0000});
  endtask
  task automatic mid_run_reset();
    logic [40:0] r;
    load_reg(5'h0a, 32'habcd_0123);
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h0a, 5'h00, 5'h0c, r);
    compare(r, {4'h8, 5'h0c, 32'habcd_0123});
    reset <= 1'h1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'h0;
    issue(awot_pkg::FN_WRAPPING_SUM, 5'h00, 5'h0a, 5'h00, 5'h0b, r);
    compare(r, {4'h8, 5'h0b, 32'h0000_0000});
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'h0;
    wrap_sum_writes();
    trap_sum_writes();
    trap_overflow_refused();
    zero_field_refused();
    other_funct_refused();
    reg_zero_dropped();
    mid_run_reset();
    tally_and_finish();
  end
endmodule
